// *** rtl/pav_pkg.sv ***
`default_nettype none
package pav_pkg;

	// ************************************************************
	// Packet identifiers and field values
	// ************************************************************
	localparam logic [7:0] PAV_ID_ADDRESS   = 8'h01;
	localparam logic [2:0] PAV_VT_SHORT_MSG = 3'h2;
	localparam logic [2:0] PAV_VT_SHORT_INS = 3'h0;
	localparam logic [2:0] PAV_VT_SECURE    = 3'h1;
	localparam logic [2:0] PAV_VT_ALPHA     = 3'h5;
	localparam logic [2:0] PAV_VT_HEXBIN    = 3'h6;
	localparam logic [1:0] PAV_ERR_LIMIT    = 2'h3;
	localparam logic [6:0] PAV_LOC_NEXT     = 7'h01;
	localparam logic [7:0] PAV_COUNT_STEP   = 8'h01;
	localparam int         PAV_PKT_BITS     = 32;
	localparam int         PAV_NUM_ADDR     = 16;

	// ************************************************************
	// Register map (word indices, taken from address bits 7:2)
	// ************************************************************
	localparam logic [5:0] PAV_REG_CTRL     = 6'h00;
	localparam logic [5:0] PAV_REG_TEMP_EN  = 6'h01;
	localparam logic [5:0] PAV_REG_STATUS   = 6'h02;
	localparam logic [5:0] PAV_REG_UCFG     = 6'h10;
	localparam logic [5:0] PAV_REG_UCFG_END = 6'h1F;

	// ************************************************************
	// User address configuration word
	// ************************************************************
	typedef struct packed {
		logic tone_only_flag;
		logic long_address_flag;
		logic enable;
	} pav_ucfg_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOOK = 4'b0010,
		ST_SEND = 4'b0100,
		ST_HOLD = 4'b1000
	} pav_state_type;

endpackage
`default_nettype wire

// *** rtl/pav_ucfg_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module pav_ucfg_mem
	import pav_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input  wire logic               hclk,    // System clock
	input  wire logic               hresetn, // Async reset, low
	input  wire logic               we,      // Write strobe
	input  wire logic [3:0]         waddr,   // Write entry
	input  wire pav_ucfg_type       wdata,   // Write value
	input  wire logic [3:0]         raddr,   // Read entry
	output pav_ucfg_type            rdata    // Registered read
);

	initial begin
		if (DEPTH < 1 || DEPTH > 16) begin
			$error("pav_ucfg_mem: DEPTH out of range");
		end
	end

	typedef struct packed {
		pav_ucfg_type [DEPTH-1:0] mem;
		pav_ucfg_type             rd;
	} pav_mem_state_type;

	pav_mem_state_type cur;
	pav_mem_state_type next_cur;

	always_comb begin
		next_cur = cur;
		if (we && (32'(waddr) < DEPTH)) begin
			next_cur.mem[waddr] = wdata;
		end
		next_cur.rd = (32'(raddr) < DEPTH) ? cur.mem[raddr] : '0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign rdata = cur.rd;

endmodule
`default_nettype wire

// *** rtl/pav_link_tx.sv ***
`timescale 1ns/1ps
`default_nettype none
module pav_link_tx
	import pav_pkg::*;
(
	input  wire logic        hclk,       // System clock
	input  wire logic        hresetn,    // Async reset, low
	input  wire logic        load,       // Take packet word
	input  wire logic [31:0] word,       // Packet word
	input  wire logic        link_clk,   // Host link clock pin
	input  wire logic        link_sel_n, // Host select pin, low
	output logic             link_data,  // Serial data out
	output logic             link_pend,  // Packet waiting
	output logic             idle        // Ready for a packet
);

	typedef struct packed {
		logic [1:0]  clk_sync;
		logic [1:0]  sel_sync;
		logic        clk_last;
		logic        sel_last;
		logic [31:0] word;
		logic [4:0]  bit_cnt;
		logic        busy;
		logic        data;
	} pav_tx_state_type;

	pav_tx_state_type cur;
	pav_tx_state_type next_cur;

	logic sel_now;
	logic clk_rise;
	logic clk_fall;

	always_comb begin
		next_cur = cur;
		sel_now  = !cur.sel_sync[1];
		clk_rise = cur.clk_sync[1] && !cur.clk_last;
		clk_fall = !cur.clk_sync[1] && cur.clk_last;
		next_cur.clk_sync = {cur.clk_sync[0], link_clk};
		next_cur.sel_sync = {cur.sel_sync[0], link_sel_n};
		next_cur.clk_last = cur.clk_sync[1];
		next_cur.sel_last = sel_now;
		if (load && !cur.busy) begin
			next_cur.word    = word;
			next_cur.busy    = 1'b1;
			next_cur.bit_cnt = '0;
		end else if (cur.busy && sel_now) begin
			if (!cur.sel_last) begin
				next_cur.bit_cnt = '0;
				next_cur.data    = cur.word[PAV_PKT_BITS-1];
			end else if (clk_rise) begin
				if (cur.bit_cnt == 5'(PAV_PKT_BITS-1)) begin
					next_cur.busy = 1'b0;
				end else begin
					next_cur.bit_cnt = cur.bit_cnt + 5'h01;
				end
			end else if (clk_fall) begin
				next_cur.data = cur.word[~cur.bit_cnt];
			end
		end else if (!sel_now) begin
			next_cur.bit_cnt = '0;
			next_cur.data    = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur <= '{clk_sync: 2'h0, sel_sync: 2'h3, clk_last: 1'b0,
				sel_last: 1'b0, word: 32'h0, bit_cnt: 5'h0,
				busy: 1'b0, data: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end

	assign link_data = cur.data;
	assign link_pend = cur.busy;
	assign idle      = !cur.busy;

endmodule
`default_nettype wire

// *** rtl/pav_framer.sv ***
`timescale 1ns/1ps
`default_nettype none
module pav_framer
	import pav_pkg::*;
#(
	parameter int NUM_ADDR = PAV_NUM_ADDR
) (
	input  wire logic        hclk,         // System clock
	input  wire logic        hresetn,      // Async reset, low
	// AHB-Lite slave
	input  wire logic        hsel,         // Slave select
	input  wire logic [31:0] haddr,        // Address
	input  wire logic [1:0]  htrans,       // Transfer type
	input  wire logic        hwrite,       // Write access
	input  wire logic [2:0]  hsize,        // Transfer size
	input  wire logic [31:0] hwdata,       // Write data
	input  wire logic        hready,       // Bus ready
	output logic             hreadyout,    // Slave ready
	output logic [31:0]      hrdata,       // Read data
	output logic             hresp,        // Response
	// Address detections from the decoding core
	input  wire logic        adr_valid,    // Address word detected
	input  wire logic [1:0]  adr_err,      // Bit errors, 3 = three+
	input  wire logic [4:0]  adr_index,    // 0-15 user, 16-31 temp
	input  wire logic        adr_priority, // Priority address
	input  wire logic [1:0]  adr_phase,    // Phase a..d
	input  wire logic [6:0]  adr_vec_loc,  // Vector word location
	// Vector words from the decoding core
	input  wire logic        vec_valid,    // Vector word received
	input  wire logic [6:0]  vec_loc,      // Frame word number
	input  wire logic [1:0]  vec_phase,    // Phase a..d
	input  wire logic        vec_err,      // More than two errors
	input  wire logic [2:0]  vec_type,     // Vector type code
	input  wire logic [13:0] vec_data,     // Data bits and subtype
	input  wire logic [20:0] vec_next_word, // Word after the vector
	output logic             core_ready,   // Core may present event
	output logic             cont_mode,    // Continuous frame decoding
	// Serial packet link
	input  wire logic        link_clk,     // Host link clock
	input  wire logic        link_sel_n,   // Host select, low
	output logic             link_data,    // Serial data, MSB first
	output logic             link_pend     // Packet waiting
);

	initial begin
		if (NUM_ADDR < 2 || NUM_ADDR > PAV_NUM_ADDR) begin
			$error("pav_framer: NUM_ADDR out of range");
		end
	end

	// ************************************************************
	// Block state
	// ************************************************************
	typedef struct packed {
		pav_state_type state;
		logic          core_ready;
		logic          a_ok;
		logic [4:0]    a_idx;
		logic          a_pri;
		logic [1:0]    a_phase;
		logic [6:0]    a_loc;
		logic          first_valid;
		logic [3:0]    first_idx;
		logic [1:0]    first_phase;
		logic          pend_valid;
		logic [6:0]    pend_loc;
		logic [1:0]    pend_phase;
		logic          pend_long;
		logic [31:0]   pkt;
		logic          msg_pend;
		logic [31:0]   msg_pkt;
		logic          load;
		logic          cont_mode;
		logic [15:0]   temp_en;
		logic [7:0]    sent_cnt;
		logic [7:0]    supp_cnt;
		logic          d_valid;
		logic          d_write;
		logic [5:0]    d_word;
		logic          hreadyout;
		logic [31:0]   hrdata;
		logic          hresp;
	} pav_top_state_type;

	pav_top_state_type cur;
	pav_top_state_type next_cur;

	pav_ucfg_type cfg_rd;
	pav_ucfg_type cfg;
	logic         tbl_we;
	logic         tx_idle;
	logic         is_temp;
	logic         vec_long;
	logic         report;
	logic         set_cont;
	logic         set_temp;
	logic [3:0]   temp_sel;
	logic [5:0]   a_word;

	// ************************************************************
	// User address table and link transmitter
	// ************************************************************
	assign tbl_we = cur.d_valid && cur.d_write &&
		(cur.d_word >= PAV_REG_UCFG) && (cur.d_word <= PAV_REG_UCFG_END);

	pav_ucfg_mem #(
		.DEPTH (NUM_ADDR)
	) u_mem (
		.hclk    (hclk),
		.hresetn (hresetn),
		.we      (tbl_we),
		.waddr   (cur.d_word[3:0]),
		.wdata   (pav_ucfg_type'(hwdata[2:0])),
		.raddr   (adr_index[3:0]),
		.rdata   (cfg_rd)
	);

	pav_link_tx u_tx (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.load       (cur.load),
		.word       (cur.pkt),
		.link_clk   (link_clk),
		.link_sel_n (link_sel_n),
		.link_data  (link_data),
		.link_pend  (link_pend),
		.idle       (tx_idle)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_cur = cur;
		next_cur.load = 1'b0;
		set_cont = 1'b0;
		set_temp = 1'b0;
		temp_sel = vec_data[5:2];
		report   = 1'b0;
		vec_long = 1'b0;
		is_temp  = cur.a_idx[4];
		cfg      = is_temp ? pav_ucfg_type'({2'b00, cur.temp_en[cur.a_idx[3:0]]})
			: cfg_rd;
		a_word   = haddr[7:2];

		unique case (cur.state)
			ST_IDLE: begin
				if (adr_valid && cur.core_ready) begin
					// Rejected words still take the look-up slot
					next_cur.a_ok    = (adr_err < PAV_ERR_LIMIT);
					next_cur.a_idx   = adr_index;
					next_cur.a_pri   = adr_priority;
					next_cur.a_phase = adr_phase;
					next_cur.a_loc   = adr_vec_loc;
					next_cur.state   = ST_LOOK;
				end else if (vec_valid && cur.core_ready) begin
					if (cur.pend_valid && vec_loc == cur.pend_loc &&
							vec_phase == cur.pend_phase) begin
						vec_long = cur.pend_long;
						next_cur.pend_valid = 1'b0;
					end
					next_cur.pkt = {1'b0, vec_loc, vec_err, vec_phase,
						2'b00, vec_type, 2'b00, vec_data};
					next_cur.state = ST_SEND;
					if (vec_type == PAV_VT_SHORT_MSG && vec_long &&
							!vec_err) begin
						next_cur.msg_pend = 1'b1;
						next_cur.msg_pkt  = {1'b0, vec_loc + PAV_LOC_NEXT,
							3'b000, vec_next_word};
					end
					if (vec_err && vec_type != PAV_VT_SHORT_MSG &&
							vec_type != PAV_VT_SHORT_INS) begin
						next_cur.supp_cnt = cur.supp_cnt + PAV_COUNT_STEP;
					end
					if (!vec_err && (vec_type == PAV_VT_HEXBIN ||
							vec_type == PAV_VT_ALPHA ||
							vec_type == PAV_VT_SECURE ||
							vec_type == PAV_VT_SHORT_INS)) begin
						set_cont = 1'b1;
					end
					if (!vec_err && vec_type == PAV_VT_SHORT_INS) begin
						set_temp = 1'b1;
					end
				end
			end
			ST_LOOK: begin
				next_cur.state = ST_IDLE;
				if (cfg.enable && cur.a_ok) begin
					if (!cfg.long_address_flag) begin
						report = 1'b1;
					end else if (!cur.a_idx[0]) begin
						next_cur.first_valid = 1'b1;
						next_cur.first_idx   = cur.a_idx[3:0];
						next_cur.first_phase = cur.a_phase;
					end else if (cur.first_valid &&
							cur.first_idx == {cur.a_idx[3:1], 1'b0} &&
							cur.first_phase == cur.a_phase) begin
						report = 1'b1;
						next_cur.first_valid = 1'b0;
					end
				end
				if (report) begin
					next_cur.pkt = {PAV_ID_ADDRESS,
						cur.a_pri, cur.a_phase,
						cfg.long_address_flag, 4'h0,
						is_temp, 3'b000, cur.a_idx[3:0],
						cfg.tone_only_flag, cur.a_loc};
					next_cur.state = ST_SEND;
					if (!cfg.tone_only_flag) begin
						next_cur.pend_valid = 1'b1;
						next_cur.pend_loc   = cur.a_loc;
						next_cur.pend_phase = cur.a_phase;
						next_cur.pend_long  = cfg.long_address_flag;
					end
				end
			end
			ST_SEND: begin
				if (tx_idle) begin
					next_cur.load     = 1'b1;
					next_cur.sent_cnt = cur.sent_cnt + PAV_COUNT_STEP;
					next_cur.state    = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cur.msg_pend) begin
					next_cur.pkt      = cur.msg_pkt;
					next_cur.msg_pend = 1'b0;
					next_cur.state    = ST_SEND;
				end else begin
					next_cur.state = ST_IDLE;
				end
			end
		endcase
		next_cur.core_ready = (next_cur.state == ST_IDLE);

		// ********************************************************
		// AHB-Lite slave
		// ********************************************************
		next_cur.hreadyout = 1'b1;
		next_cur.hresp     = 1'b0;
		if (cur.d_valid && cur.d_write) begin
			if (cur.d_word == PAV_REG_CTRL) begin
				next_cur.cont_mode = hwdata[0];
			end
			if (cur.d_word == PAV_REG_TEMP_EN) begin
				next_cur.temp_en = hwdata[15:0];
			end
		end
		if (set_cont) begin
			next_cur.cont_mode = 1'b1;
		end
		if (set_temp) begin
			next_cur.temp_en[temp_sel] = 1'b1;
		end
		next_cur.d_valid = hsel && hready && htrans[1];
		next_cur.d_write = hwrite;
		next_cur.d_word  = a_word;
		if (hsel && hready && htrans[1] && !hwrite) begin
			if (a_word == PAV_REG_CTRL) begin
				next_cur.hrdata = {31'h0, cur.cont_mode};
			end else if (a_word == PAV_REG_TEMP_EN) begin
				next_cur.hrdata = {16'h0, cur.temp_en};
			end else if (a_word == PAV_REG_STATUS) begin
				next_cur.hrdata = {8'h0, cur.supp_cnt, cur.sent_cnt,
					5'h00, cur.pend_valid, cur.cont_mode, !tx_idle};
			end else begin
				next_cur.hrdata = 32'h0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur           <= '0;
			cur.state     <= ST_IDLE;
			cur.hreadyout <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign hreadyout  = cur.hreadyout;
	assign hrdata     = cur.hrdata;
	assign hresp      = cur.hresp;
	assign core_ready = cur.core_ready;
	assign cont_mode  = cur.cont_mode;

endmodule
`default_nettype wire

// *** sim/pav_framer_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pav_framer_props
	import pav_pkg::*;
(
	input wire logic        hclk,       // Clock
	input wire logic        hresetn,    // Reset, low
	input wire logic        hsel,       // Select
	input wire logic [31:0] haddr,      // Address
	input wire logic [1:0]  htrans,     // Transfer
	input wire logic        hwrite,     // Write
	input wire logic [31:0] hwdata,     // Write data
	input wire logic        hready,     // Bus ready
	input wire logic        hreadyout,  // Slave ready
	input wire logic        hresp,      // Response
	input wire logic        adr_valid,  // Address event
	input wire logic [1:0]  adr_err,    // Error count
	input wire logic        core_ready, // Core free
	input wire logic        cont_mode,  // Continuous
	input wire logic        link_clk,   // Link clock
	input wire logic        link_sel_n, // Select
	input wire logic        link_data,  // Data
	input wire logic        link_pend   // Pending
);
	logic ctrl_wr;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ****************
	// Control write in its data phase
	// ****************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctrl_wr <= 1'b0;
		else if (hready)
			ctrl_wr <= hsel && htrans[1] && hwrite
				&& haddr[7:2] == PAV_REG_CTRL;
	end
	a_hready_one: assert property (hreadyout)
		else $error("slave inserted a wait state");
	a_resp_okay: assert property (!hresp)
		else $error("slave answered with an error");
	a_ready_drop: assert property (core_ready && adr_valid |=> !core_ready)
		else $error("address event not taken");
	a_bad_quiet: assert property (
		core_ready && adr_valid && adr_err == 2'h3 && !link_pend
		|=> !link_pend [*4])
		else $error("rejected address made a packet");
	a_bad_back: assert property (
		core_ready && adr_valid && adr_err == 2'h3 |-> ##[2:5] core_ready)
		else $error("rejected address held the core");
	a_ctrl_clear: assert property (
		ctrl_wr && hready && !hwdata[0] |=> !cont_mode)
		else $error("mode not cleared by write");
	a_pend_sel: assert property (
		link_sel_n [*4] ##0 link_pend |=> link_pend)
		else $error("packet dropped without select");
	a_data_still: assert property (
		link_clk [*3] ##0 link_pend |-> $stable(link_data))
		else $error("data moved while link clock high");
endmodule
bind pav_framer pav_framer_props pav_framer_props_inst (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.hreadyout, .hresp, .adr_valid, .adr_err, .core_ready, .cont_mode,
	.link_clk, .link_sel_n, .link_data, .link_pend
);
`default_nettype wire

// *** sim/pav_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pav_host_model (
	input wire logic    hclk,       // System clock
	input wire logic    link_data,  // Serial data
	input wire logic    link_pend,  // Packet waiting
	output logic        link_clk,   // Still between frames
	output logic        link_sel_n, // Select, low
	output logic [31:0] pkt,        // Packet read
	output logic        pkt_valid   // Packet read pulse
);
	logic [31:0] sh;
	int          n;
	initial begin
		link_clk = 1'b0;
		link_sel_n = 1'b1;
		pkt = 32'h0;
		pkt_valid = 1'b0;
		n = 0;
		forever begin
			wait (link_pend === 1'b1);
			// Off the clock edges, some packets taken late
			#(7 + 300 * (n % 3));
			n++;
			link_sel_n = 1'b0;
			#100;
			for (int b = 31; b >= 0; b--) begin
				link_clk = 1'b1;
				sh[b] = link_data;
				#100;
				link_clk = 1'b0;
				#100;
			end
			link_sel_n = 1'b1;
			@(posedge hclk);
			pkt <= sh;
			pkt_valid <= 1'b1;
			@(posedge hclk);
			pkt_valid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** sim/paging_address_vector_packets_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module paging_address_vector_packets_bench
	import pav_pkg::*;
;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        hready, hreadyout, hresp, core_ready, cont_mode, pkt_valid;
	logic        adr_valid = 1'b0, adr_priority = 1'b0, vec_valid = 1'b0;
	logic        vec_err = 1'b0, link_clk, link_sel_n, link_data, link_pend;
	logic [1:0]  htrans = 2'h0, adr_err = 2'h0, adr_phase = 2'h0, ph;
	logic [1:0]  vec_phase = 2'h0;
	logic [2:0]  hsize = 3'h2, vec_type = 3'h0;
	logic [4:0]  adr_index = 5'h0;
	logic [6:0]  adr_vec_loc = 7'h0, vec_loc = 7'h0, loc;
	logic [13:0] vec_data = 14'h0;
	logic [20:0] vec_next_word = 21'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, pkt, rs = 32'h15;
	logic [63:0] q[$], e;
	logic [2:0]  vt[4] = '{3'h0, 3'h1, 3'h5, 3'h6};
	int          fail_count = 0, n_compared = 0, cyc = 0;

	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;

	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [63:0] pa(logic [4:0] ix, logic lg, to);
		logic [31:0] m;
		m = to ? 32'hFFF0_FF80 : 32'hFFF0_FFFF;
		return {m, m & {8'h01, rs[20], ph, lg, 4'h0, ix[4], 3'h0,
			ix[3:0], to, loc}};
	endfunction
	function automatic logic [63:0] pv(logic er, logic [2:0] t,
		logic [13:0] d);
		return {32'hFFE7_3FFF, 32'hFFE7_3FFF & {1'b0, loc, er, ph, 2'h0,
			t, 2'h0, d}};
	endfunction
	function automatic logic [63:0] pm();
		return {32'hFFFF_FFFF, 1'b0, loc + 7'h01, 3'h0, rs[31:11]};
	endfunction

	task automatic check(string nm, logic [31:0] s, logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic close_out();
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic ahb(logic w, logic [31:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic rdy();
		do @(posedge hclk); while (core_ready !== 1'b1);
	endtask
	task automatic roll();
		void'(xs());
		ph = rs[1:0];
		loc = 7'(rs[15:8] % 8'd86) + 7'h02;
	endtask
	task automatic adr_ev(logic [1:0] er, logic [4:0] ix);
		rdy();
		adr_err <= er;
		adr_index <= ix;
		adr_phase <= ph;
		adr_vec_loc <= loc;
		adr_priority <= rs[20];
		adr_valid <= 1'b1;
		@(posedge hclk);
		adr_valid <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
	task automatic vec_ev(logic er, logic [2:0] t, logic [13:0] d);
		rdy();
		vec_loc <= loc;
		vec_phase <= ph;
		vec_err <= er;
		vec_type <= t;
		vec_data <= d;
		vec_next_word <= rs[31:11];
		vec_valid <= 1'b1;
		@(posedge hclk);
		vec_valid <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
	task automatic page(logic [1:0] er, logic [4:0] ix, logic lg, to, ve,
		logic [2:0] t, logic [13:0] d);
		roll();
		if (lg)
			adr_ev(2'h0, ix - 5'h1);
		adr_ev(er, ix);
		if (er != 2'h3) begin
			q.push_back(pa(ix, lg, to));
			if (!to) begin
				q.push_back(pv(ve, t, d));
				if (lg && !ve && t == PAV_VT_SHORT_MSG)
					q.push_back(pm());
				vec_ev(ve, t, d);
			end
		end
	endtask

	pav_framer #(.NUM_ADDR(PAV_NUM_ADDR)) pav_framer_inst (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hrdata, .hresp, .adr_valid, .adr_err,
		.adr_index, .adr_priority, .adr_phase, .adr_vec_loc, .vec_valid,
		.vec_loc, .vec_phase, .vec_err, .vec_type, .vec_data,
		.vec_next_word, .core_ready, .cont_mode, .link_clk, .link_sel_n,
		.link_data, .link_pend
	);
	pav_host_model pav_host_model_inst (
		.hclk, .link_data, .link_pend, .link_clk, .link_sel_n, .pkt,
		.pkt_valid
	);

	// ****************
	// Packet watcher and time limit
	// ****************
	always @(posedge hclk) begin
		if (pkt_valid === 1'b1) begin
			if (q.size() == 0)
				check("spare packet", 32'h1, 32'h0);
			else begin
				e = q.pop_front();
				check("packet", pkt & e[63:32], e[31:0]);
			end
		end
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			close_out();
		end
	end

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		ahb(1'b1, 32'h40, 32'h1);
		ahb(1'b1, 32'h44, 32'h5);
		ahb(1'b1, 32'h48, 32'h3);
		ahb(1'b1, 32'h4C, 32'h3);
		ahb(1'b0, 32'h40, 32'h0);
		check("ucfg read", r, 32'h0);
		ahb(1'b0, 32'h80, 32'h0);
		check("unmapped read", r, 32'h0);
		for (int k = 3; k >= 0; k--)
			page(2'(k), 5'h0, 1'b0, 1'b0, 1'b0, PAV_VT_SHORT_MSG,
				rs[13:0]);
		roll();
		adr_ev(2'h0, 5'h4);
		adr_ev(2'h0, 5'h13);
		check("mode", {31'h0, cont_mode}, 32'h0);
		page(2'h0, 5'h1, 1'b0, 1'b1, 1'b0, 3'h2, 14'h0);
		page(2'h0, 5'h3, 1'b1, 1'b0, 1'b0, 3'h2, rs[13:0]);
		page(2'h0, 5'h3, 1'b1, 1'b0, 1'b1, 3'h2, rs[13:0]);
		for (int k = 0; k < 4; k++) begin
			ahb(1'b1, 32'h0, 32'h0);
			rdy();
			check("mode clear", {31'h0, cont_mode}, 32'h0);
			page(2'h0, 5'h0, 1'b0, 1'b0, 1'b0, vt[k], 14'h0024);
			rdy();
			check("mode set", {31'h0, cont_mode}, 32'h1);
		end
		page(2'h0, 5'h19, 1'b0, 1'b0, 1'b0, 3'h2, rs[13:0]);
		rdy();
		ahb(1'b0, 32'h4, 32'h0);
		check("temp enables", r & 32'hFFFF, 32'h0200);
		for (int k = 0; k < 9000 && q.size() != 0; k++)
			@(posedge hclk);
		check("reports left", 32'(q.size()), 32'h0);
		ahb(1'b0, 32'h8, 32'h0);
		check("status", r & 32'h7, 32'h2);
		repeat (600) @(posedge hclk);
		close_out();
	end
endmodule
`default_nettype wire
